//--- src/cdt_pkg.sv
/*
  cdt_pkg: shared constants and types of the compare output and dead-time unit.
  Assumes a 32-bit classic Wishbone register bus with byte addresses.
*/
// Function
// [RULE_01] force strobe applies the channel's compare action in non-PWM modes
// [RULE_02] forced action sets no flag and leaves the counter alone
// [RULE_03] a counter write blocks every compare match in the next timer cycle
// [RULE_04] compare output mode is unbuffered and acts from the next match
// [RULE_05] waveform output keeps its state across waveform mode changes
// [RULE_06] PWM with mode 01 gives a complementary pair with dead time
// [RULE_07] three independent dead-time generators, rise and fall delays separate
// [RULE_08] four-bit down counter times dead time, zero ends insertion
// [RULE_09] dead-time prescaler divides timer clock by 1, 2, 4 or 8
// [RULE_10] waveform edge starts dead time, rising output held until zero
// [RULE_11] counter loads rise or fall nibble by edge direction
// [RULE_12] upper nibble delays true rise, lower nibble delays complement rise
// [RULE_13] outputs lag waveform by at least one cycle at zero dead time
// [RULE_14] inversion bit inverts both pair outputs, both high in dead time
// [RULE_15] non-PWM mode only resynchronises the waveform by one cycle
// [RULE_16] PWM with mode other than 01 behaves like non-PWM path
// [RULE_17] reset clears the generator's compare outputs to zero
// [RULE_18] nonzero mode overrides port value, direction bit still gates pin
// [RULE_19] override depends only on a mode bit being set
// [RULE_20] mode zero makes no waveform change on a compare match
// [RULE_21] software sets the waveform level before enabling the pin
// [RULE_22] software avoids counter writes that equal a compare value
// [RULE_23] counter equal compare value signals a match, flag set next cycle
// [RULE_24] non-PWM match toggles, clears or sets by mode 01, 10, 11
// [RULE_25] fast PWM non-inverting clears on match, sets on wrap; inverting opposite
// [RULE_26] a new waveform edge restarts a running dead-time count
// [RULE_27] force strobes are one-cycle pulses and read back zero
package cdt_pkg;
  localparam int CDT_NCH = 3;
  // register byte offsets
  localparam logic [7:0] CDT_OFS_CTRL = 8'h00;
  localparam logic [7:0] CDT_OFS_MODE = 8'h04;
  localparam logic [7:0] CDT_OFS_FORCE = 8'h08;
  localparam logic [7:0] CDT_OFS_COUNT = 8'h0C;
  localparam logic [7:0] CDT_OFS_CMP0 = 8'h10;
  localparam logic [7:0] CDT_OFS_CMP1 = 8'h14;
  localparam logic [7:0] CDT_OFS_CMP2 = 8'h18;
  localparam logic [7:0] CDT_OFS_TOP = 8'h1C;
  localparam logic [7:0] CDT_OFS_DT = 8'h20;
  localparam logic [7:0] CDT_OFS_PORT = 8'h24;
  localparam logic [7:0] CDT_OFS_STAT = 8'h28;
  // control, status and port field positions
  localparam int CDT_CTRL_PWM = 0;
  localparam int CDT_CTRL_INV = 1;
  localparam int CDT_CTRL_PS_LO = 2;
  localparam int CDT_CTRL_RUN = 4;
  localparam int CDT_STAT_WAVE = 4;
  localparam int CDT_STAT_PIN = 8;
  localparam int CDT_PORT_VAL = 8;
  // compare output modes
  localparam logic [1:0] CDT_MODE_OFF = 2'h0;
  localparam logic [1:0] CDT_MODE_TGL = 2'h1;
  localparam logic [1:0] CDT_MODE_CLR = 2'h2;
  localparam logic [1:0] CDT_MODE_SET = 2'h3;
  // reset values
  localparam logic [7:0] CDT_RST_TOP = 8'hFF;
  localparam logic [7:0] CDT_RST_DT = 8'h00;
  typedef enum logic [1:0] {CDT_BUS_IDLE = 2'h0, CDT_BUS_ACK = 2'h1} cdt_bus_st_t;
  typedef struct packed {
    logic [3:0] rise;
    logic [3:0] fall;
  } cdt_dt_cfg_t;
endpackage

//--- src/cdt_prescaler.sv
/*
  cdt_prescaler: one-cycle tick every 1, 2, 4 or 8 timer clocks.
  Assumes the timer clock is clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module cdt_prescaler import cdt_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] sel_i,
  output logic tick_o
);
  logic [2:0] cnt_reg;
  logic [2:0] mask;
  // mask of low bits that must be zero for a tick
  assign mask = 3'((4'h1 << sel_i) - 4'h1);
  assign tick_o = ((cnt_reg & mask) == 3'h0); // [RULE_09]
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
    end
  end
endmodule
`default_nettype wire

//--- src/cdt_deadtime.sv
/*
  cdt_deadtime: one dead-time generator turning a waveform into a pin pair.
  Assumes wave_i comes from a flop on clk_i and tick_i from the prescaler.
*/
`timescale 1ns/1ps
`default_nettype none
module cdt_deadtime import cdt_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wave_i,
  input wire logic tick_i,
  input wire logic en_i,
  input wire logic inv_i,
  input wire cdt_dt_cfg_t cfg_i,
  output logic true_o,
  output logic comp_o
);
  logic wave_d_reg;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic edge_w;
  logic busy_w;
  logic true_next;
  logic comp_next;
  //////////////////////////////////////////////////////////////////////
  // edge detect and reload, a new edge restarts the count
  assign edge_w = wave_i ^ wave_d_reg; // [RULE_10]
  assign cnt_next = (edge_w && en_i) ? (wave_i ? cfg_i.rise : cfg_i.fall) : // [RULE_11] [RULE_12] [RULE_26]
                    ((cnt_reg != 4'h0) && tick_i) ? cnt_reg - 4'h1 : cnt_reg; // [RULE_08]
  assign busy_w = (cnt_next != 4'h0); // [RULE_08]
  // rising edges wait for zero, falling edges pass at once
  assign true_next = en_i ? ((wave_i & ~busy_w) ^ inv_i) : wave_i; // [RULE_06] [RULE_14] [RULE_16]
  assign comp_next = en_i ? ((~wave_i & ~busy_w) ^ inv_i) : ~wave_i; // [RULE_14]
  // outputs registered, so they lag the waveform by a cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wave_d_reg <= 1'b0;
      cnt_reg <= 4'h0;
      true_o <= 1'b0; // [RULE_17]
      comp_o <= 1'b0;
    end else begin
      wave_d_reg <= wave_i;
      cnt_reg <= en_i ? cnt_next : 4'h0;
      true_o <= true_next; // [RULE_13] [RULE_15]
      comp_o <= comp_next;
    end
  end
  //////////////////////////////////////////////////////////////////////
  property p_reset_low;
    @(posedge clk_i) disable iff (rst_i) $fell(rst_i) |-> !true_o && !comp_o;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("outputs not cleared by reset"); // [RULE_17]
  property p_sync_lag;
    @(posedge clk_i) disable iff (rst_i) !en_i |=> true_o == $past(wave_i);
  endproperty
  a_sync_lag: assert property (p_sync_lag) else $error("true output not one cycle late"); // [RULE_15]
  property p_no_overlap;
    @(posedge clk_i) disable iff (rst_i) (en_i && !inv_i) |=> !(true_o && comp_o);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("pair outputs overlap"); // [RULE_10]
  c_dead_time: cover property (@(posedge clk_i) disable iff (rst_i) en_i && edge_w && busy_w);
endmodule
`default_nettype wire

//--- src/cdt_top.sv
/*
  cdt_top: compare outputs, force strobes, match blocking and three
  dead-time generators, registers reached over classic Wishbone.
  Assumes the timer clock is clk_i and reset is synchronous active high.
*/
// Our own choices: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cdt_top import cdt_pkg::*; #(
  parameter int NCH = CDT_NCH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic [NCH-1:0] pin_true_o,
  output logic [NCH-1:0] pin_true_oe_o,
  output logic [NCH-1:0] pin_comp_o,
  output logic [NCH-1:0] pin_comp_oe_o,
  output logic [NCH-1:0] compare_match_flag_o
);
  //////////////////////////////////////////////////////////////////////
  // registers
  logic pwm_reg;
  logic pwm_inversion_bit_reg;
  logic [1:0] dead_time_prescale_sel_reg;
  logic run_reg;
  logic [2*NCH-1:0] mode_reg;
  logic [NCH-1:0] force_reg;
  logic [7:0] timer_count_value_reg;
  logic [7:0] cmp_reg [NCH];
  logic [7:0] top_compare_value_reg;
  logic [7:0] dead_time_register_reg;
  logic [2*NCH-1:0] compare_pin_direction_bit_reg;
  logic [2*NCH-1:0] port_value_reg;
  logic [NCH-1:0] waveform_output_reg;
  logic blocked_reg;
  cdt_bus_st_t bus_st_reg;
  cdt_bus_st_t bus_st_next;
  logic [31:0] rdata_next;
  //////////////////////////////////////////////////////////////////////
  // bus decode
  logic req_w;
  logic wr_w;
  logic lane0_w;
  logic lane1_w;
  logic hit_ctrl;
  logic hit_mode;
  logic hit_force;
  logic hit_count;
  logic hit_top;
  logic hit_dt;
  logic hit_port;
  logic hit_stat;
  logic [NCH-1:0] hit_cmp;
  assign req_w = cyc_i && stb_i;
  assign wr_w = req_w && we_i && (bus_st_reg == CDT_BUS_ACK);
  assign lane0_w = sel_i[0];
  assign lane1_w = sel_i[1];
  assign hit_ctrl = (adr_i == CDT_OFS_CTRL);
  assign hit_mode = (adr_i == CDT_OFS_MODE);
  assign hit_force = (adr_i == CDT_OFS_FORCE);
  assign hit_count = (adr_i == CDT_OFS_COUNT);
  assign hit_top = (adr_i == CDT_OFS_TOP);
  assign hit_dt = (adr_i == CDT_OFS_DT);
  assign hit_port = (adr_i == CDT_OFS_PORT);
  assign hit_stat = (adr_i == CDT_OFS_STAT);
  assign hit_cmp[0] = (adr_i == CDT_OFS_CMP0);
  assign hit_cmp[1] = (adr_i == CDT_OFS_CMP1);
  assign hit_cmp[2] = (adr_i == CDT_OFS_CMP2);
  // ack one cycle after the request, dropped the cycle after
  assign bus_st_next = (req_w && bus_st_reg == CDT_BUS_IDLE) ? CDT_BUS_ACK : CDT_BUS_IDLE;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_st_reg <= CDT_BUS_IDLE;
      ack_o <= 1'b0;
      dat_o <= 32'h0;
    end else begin
      bus_st_reg <= bus_st_next;
      ack_o <= (bus_st_next == CDT_BUS_ACK);
      dat_o <= rdata_next;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // timer counter and compare matches
  logic [NCH-1:0] match_w;
  logic wrap_w;
  logic cnt_wr_w;
  assign cnt_wr_w = wr_w && hit_count && lane0_w;
  assign wrap_w = run_reg && (timer_count_value_reg == top_compare_value_reg) && !cnt_wr_w;
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_match
      assign match_w[g] = (timer_count_value_reg == cmp_reg[g]) && !blocked_reg; // [RULE_03] [RULE_23]
    end
  endgenerate
  // a counter write wins over counting and blocks the next cycle's match
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_count_value_reg <= 8'h00;
      blocked_reg <= 1'b0;
    end else begin
      blocked_reg <= cnt_wr_w; // [RULE_03]
      if (cnt_wr_w) begin
        timer_count_value_reg <= dat_i[7:0];
      end else if (wrap_w) begin
        timer_count_value_reg <= 8'h00;
      end else if (run_reg) begin
        timer_count_value_reg <= timer_count_value_reg + 8'h01;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // waveform action for one channel
  function automatic logic wave_act(input logic [1:0] mode, input logic pwm,
                                    input logic hit, input logic wrap, input logic cur);
    logic r;
    r = cur;
    if (!pwm) begin
      if (hit) begin
        case (mode)
          CDT_MODE_TGL: r = ~cur; // [RULE_24]
          CDT_MODE_CLR: r = 1'b0;
          CDT_MODE_SET: r = 1'b1;
          default: r = cur; // [RULE_20]
        endcase
      end
    end else if (mode != CDT_MODE_OFF) begin
      // complementary and non-inverting clear on match, set at wrap
      if (hit) begin
        r = (mode == CDT_MODE_SET); // [RULE_25]
      end else if (wrap) begin
        r = (mode != CDT_MODE_SET);
      end
    end
    return r;
  endfunction
  logic [NCH-1:0] wave_next;
  logic [NCH-1:0] flag_next;
  logic [NCH-1:0] flag_clr_w;
  assign flag_clr_w = (wr_w && hit_stat && lane0_w) ? dat_i[NCH-1:0] : '0;
  generate
    for (g = 0; g < NCH; g++) begin : g_wave
      // the mode field is read live, force counts as a match only outside PWM
      assign wave_next[g] = wave_act(mode_reg[2*g +: 2], pwm_reg, // [RULE_04] [RULE_05]
                                     match_w[g] || (force_reg[g] && !pwm_reg), // [RULE_01]
                                     wrap_w, waveform_output_reg[g]);
      // set wins over the write-one clear; force never sets the flag
      assign flag_next[g] = match_w[g] || (compare_match_flag_o[g] && !flag_clr_w[g]); // [RULE_02]
    end
  endgenerate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      waveform_output_reg <= '0;
      compare_match_flag_o <= '0;
    end else begin
      waveform_output_reg <= wave_next;
      compare_match_flag_o <= flag_next; // [RULE_23]
    end
  end
  //////////////////////////////////////////////////////////////////////
  // software writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_reg <= 1'b0;
      pwm_inversion_bit_reg <= 1'b0;
      dead_time_prescale_sel_reg <= 2'h0;
      run_reg <= 1'b0;
      mode_reg <= '0;
      force_reg <= '0;
      top_compare_value_reg <= CDT_RST_TOP;
      dead_time_register_reg <= CDT_RST_DT;
      compare_pin_direction_bit_reg <= '0;
      port_value_reg <= '0;
      for (int i = 0; i < NCH; i++) begin
        cmp_reg[i] <= 8'h00;
      end
    end else begin
      force_reg <= (wr_w && hit_force && lane0_w) ? dat_i[NCH-1:0] : '0; // [RULE_27]
      if (wr_w && hit_ctrl && lane0_w) begin
        pwm_reg <= dat_i[CDT_CTRL_PWM];
        pwm_inversion_bit_reg <= dat_i[CDT_CTRL_INV];
        dead_time_prescale_sel_reg <= dat_i[CDT_CTRL_PS_LO +: 2];
        run_reg <= dat_i[CDT_CTRL_RUN];
      end
      if (wr_w && hit_mode && lane0_w) begin
        mode_reg <= dat_i[2*NCH-1:0];
      end
      if (wr_w && hit_top && lane0_w) begin
        top_compare_value_reg <= dat_i[7:0];
      end
      if (wr_w && hit_dt && lane0_w) begin
        dead_time_register_reg <= dat_i[7:0];
      end
      if (wr_w && hit_port && lane0_w) begin
        compare_pin_direction_bit_reg <= dat_i[2*NCH-1:0];
      end
      if (wr_w && hit_port && lane1_w) begin
        port_value_reg <= dat_i[CDT_PORT_VAL +: 2*NCH];
      end
      for (int i = 0; i < NCH; i++) begin
        if (wr_w && hit_cmp[i] && lane0_w) begin
          cmp_reg[i] <= dat_i[7:0];
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // dead-time generators
  logic dt_tick;
  logic [NCH-1:0] oc_true;
  logic [NCH-1:0] oc_comp;
  cdt_dt_cfg_t dt_cfg;
  assign dt_cfg.rise = dead_time_register_reg[7:4]; // [RULE_12]
  assign dt_cfg.fall = dead_time_register_reg[3:0];
  cdt_prescaler u_ps (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sel_i(dead_time_prescale_sel_reg),
    .tick_o(dt_tick)
  );
  generate
    for (g = 0; g < NCH; g++) begin : g_dt
      cdt_deadtime u_dt ( // [RULE_07]
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wave_i(waveform_output_reg[g]),
        .tick_i(dt_tick),
        .en_i(pwm_reg && (mode_reg[2*g +: 2] == CDT_MODE_TGL)), // [RULE_06] [RULE_16]
        .inv_i(pwm_inversion_bit_reg),
        .cfg_i(dt_cfg),
        .true_o(oc_true[g]),
        .comp_o(oc_comp[g])
      );
    end
  endgenerate
  //////////////////////////////////////////////////////////////////////
  // port override, direction bits drive the enables
  logic [NCH-1:0] ovr_w;
  generate
    for (g = 0; g < NCH; g++) begin : g_pin
      assign ovr_w[g] = |mode_reg[2*g +: 2]; // [RULE_19]
    end
  endgenerate
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_true_o <= '0;
      pin_comp_o <= '0;
      pin_true_oe_o <= '0;
      pin_comp_oe_o <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        pin_true_o[i] <= ovr_w[i] ? oc_true[i] : port_value_reg[2*i]; // [RULE_18]
        pin_comp_o[i] <= ovr_w[i] ? oc_comp[i] : port_value_reg[2*i+1];
        pin_true_oe_o[i] <= compare_pin_direction_bit_reg[2*i];
        pin_comp_oe_o[i] <= compare_pin_direction_bit_reg[2*i+1];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // read mux, unmapped reads return zero
  always_comb begin
    rdata_next = 32'h0;
    if (bus_st_next == CDT_BUS_ACK && !we_i) begin
      if (hit_ctrl) begin
        rdata_next[CDT_CTRL_PWM] = pwm_reg;
        rdata_next[CDT_CTRL_INV] = pwm_inversion_bit_reg;
        rdata_next[CDT_CTRL_PS_LO +: 2] = dead_time_prescale_sel_reg;
        rdata_next[CDT_CTRL_RUN] = run_reg;
      end
      if (hit_mode) rdata_next[2*NCH-1:0] = mode_reg;
      if (hit_count) rdata_next[7:0] = timer_count_value_reg;
      if (hit_top) rdata_next[7:0] = top_compare_value_reg;
      if (hit_dt) rdata_next[7:0] = dead_time_register_reg;
      if (hit_port) begin
        rdata_next[2*NCH-1:0] = compare_pin_direction_bit_reg;
        rdata_next[CDT_PORT_VAL +: 2*NCH] = port_value_reg;
      end
      if (hit_stat) begin
        rdata_next[NCH-1:0] = compare_match_flag_o;
        rdata_next[CDT_STAT_WAVE +: NCH] = waveform_output_reg;
        rdata_next[CDT_STAT_PIN +: NCH] = oc_true;
      end
      for (int i = 0; i < NCH; i++) begin
        if (hit_cmp[i]) rdata_next[7:0] = cmp_reg[i];
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  // checks
  property p_force_noflag;
    @(posedge clk_i) disable iff (rst_i)
      force_reg[0] && !match_w[0] && !compare_match_flag_o[0] |=> !compare_match_flag_o[0];
  endproperty
  a_force_noflag: assert property (p_force_noflag) else $error("force set a flag"); // [RULE_02]
  property p_block;
    @(posedge clk_i) disable iff (rst_i) cnt_wr_w |=> match_w == '0;
  endproperty
  a_block: assert property (p_block) else $error("match after counter write"); // [RULE_03]
  property p_flag;
    @(posedge clk_i) disable iff (rst_i) match_w[0] |=> compare_match_flag_o[0];
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set after match"); // [RULE_23]
  property p_toggle;
    @(posedge clk_i) disable iff (rst_i)
      !pwm_reg && mode_reg[1:0] == CDT_MODE_TGL && match_w[0]
      |=> waveform_output_reg[0] != $past(waveform_output_reg[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle on match"); // [RULE_24]
  property p_mode_off;
    @(posedge clk_i) disable iff (rst_i)
      mode_reg[1:0] == CDT_MODE_OFF |=> $stable(waveform_output_reg[0]);
  endproperty
  a_mode_off: assert property (p_mode_off) else $error("waveform moved with mode zero"); // [RULE_20]
  property p_force_clr;
    @(posedge clk_i) disable iff (rst_i)
      !pwm_reg && force_reg[0] && mode_reg[1:0] == CDT_MODE_CLR |=> !waveform_output_reg[0];
  endproperty
  a_force_clr: assert property (p_force_clr) else $error("force did not clear"); // [RULE_01]
  c_force: cover property (@(posedge clk_i) disable iff (rst_i) force_reg[0] && !pwm_reg);
  c_blocked: cover property (@(posedge clk_i) disable iff (rst_i)
    blocked_reg && timer_count_value_reg == cmp_reg[0]);
  // strobes never stand a second cycle, the bus cannot write twice in a row
  property p_force_pulse;
    @(posedge clk_i) disable iff (rst_i) force_reg != '0 |=> force_reg == '0;
  endproperty
  a_force_pulse: assert property (p_force_pulse) else $error("force strobe held"); // [RULE_27]
  // a cpu write to the counter beats counting and wrapping
  property p_count_write;
    @(posedge clk_i) disable iff (rst_i) cnt_wr_w |=> timer_count_value_reg == $past(dat_i[7:0]);
  endproperty
  a_count_write: assert property (p_count_write) else $error("counter write lost"); // [RULE_03]
  // override set means the pin follows the generator one cycle later
  property p_pin_ovr;
    @(posedge clk_i) disable iff (rst_i) ovr_w[0] |=> pin_true_o[0] == $past(oc_true[0]);
  endproperty
  a_pin_ovr: assert property (p_pin_ovr) else $error("pin not from compare output"); // [RULE_18]
  // complementary mode sets the waveform when the counter wraps
  property p_pwm_wrap;
    @(posedge clk_i) disable iff (rst_i)
      pwm_reg && mode_reg[1:0] == CDT_MODE_TGL && wrap_w && !match_w[0] |=> waveform_output_reg[0];
  endproperty
  a_pwm_wrap: assert property (p_pwm_wrap) else $error("waveform not set at wrap"); // [RULE_25]
  c_pwm_wrap: cover property (@(posedge clk_i) disable iff (rst_i) pwm_reg && wrap_w);
endmodule
`default_nettype wire

//--- verification/cdt_switch_model.sv
/*
  cdt_switch_model: gate drivers of the external power switches on the pin pairs.
  Assumes a released pin is pulled to the inactive level of its switch.
*/
`timescale 1ns/1ps
`default_nettype none
module cdt_switch_model #(
  parameter int NCH = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic inv_i,
  input wire logic [NCH-1:0] true_i,
  input wire logic [NCH-1:0] true_oe_i,
  input wire logic [NCH-1:0] comp_i,
  input wire logic [NCH-1:0] comp_oe_i,
  output logic [15:0] overlap_o,
  output logic [7:0] gap_true_o,
  output logic [7:0] gap_comp_o
);
  logic [NCH-1:0] on_t;
  logic [NCH-1:0] on_c;
  logic [7:0] idle_reg;
  logic prev_t_reg;
  logic prev_c_reg;
  ////////////////////////////////////////////////////////////////////////////////
  // switch conducts at its active level, low when inversion is in use
  assign on_t = true_oe_i & (true_i ^ {NCH{inv_i}});
  assign on_c = comp_oe_i & (comp_i ^ {NCH{inv_i}});
  // shoot-through count and channel 0 off time before each turn-on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overlap_o <= 16'h0000;
      idle_reg <= 8'h00;
      gap_true_o <= 8'h00;
      gap_comp_o <= 8'h00;
      prev_t_reg <= 1'b0;
      prev_c_reg <= 1'b0;
    end else begin
      if (|(on_t & on_c)) begin
        overlap_o <= overlap_o + 16'h0001;
      end
      idle_reg <= (on_t[0] | on_c[0]) ? 8'h00 : idle_reg + 8'h01;
      if (on_t[0] && !prev_t_reg) begin
        gap_true_o <= idle_reg;
      end
      if (on_c[0] && !prev_c_reg) begin
        gap_comp_o <= idle_reg;
      end
      prev_t_reg <= on_t[0];
      prev_c_reg <= on_c[0];
    end
  end
endmodule
`default_nettype wire

//--- verification/tb_cdt_top.sv
/*
  tb_cdt_top: register-level tests of the compare output and dead-time unit.
  Assumes the design answers every Wishbone request with one ack.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_cdt_top import cdt_pkg::*;;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic [2:0] pin_t;
  logic [2:0] oe_t;
  logic [2:0] pin_c;
  logic [2:0] oe_c;
  logic [2:0] flag;
  logic inv_r = 1'b0;
  logic [15:0] overlap;
  logic [7:0] gap_t;
  logic [7:0] gap_c;
  logic [31:0] q;
  logic [1:0] seq [5] = '{CDT_MODE_SET, CDT_MODE_TGL, CDT_MODE_OFF, CDT_MODE_TGL, CDT_MODE_CLR};
  logic w = 1'b0;
  int failures = 0;
  int num_checks = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // clock at 25 MHz
  always #20 clk_i = ~clk_i;
  cdt_top cdt_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .pin_true_o(pin_t), .pin_true_oe_o(oe_t), .pin_comp_o(pin_c), .pin_comp_oe_o(oe_c),
    .compare_match_flag_o(flag));
  cdt_switch_model cdt_switch_model_inst (.clk_i(clk_i), .rst_i(rst_i), .inv_i(inv_r),
    .true_i(pin_t), .true_oe_i(oe_t), .comp_i(pin_c), .comp_oe_i(oe_c),
    .overlap_o(overlap), .gap_true_o(gap_t), .gap_comp_o(gap_c));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one classic Wishbone cycle, held until ack is sampled
  task automatic wb(input logic w_en, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w_en;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  // pwm pair run with given prescale and inversion, off times judged on channel 0
  task automatic dt_run(input int ps, input logic inv);
    logic [15:0] ov;
    wr(CDT_OFS_CTRL, 32'h11 | (32'(inv) << 1) | (32'(ps) << 2));
    inv_r <= inv;
    repeat (60) @(posedge clk_i);
    ov = overlap;
    repeat (300) @(posedge clk_i);
    chk("overlap", {16'h0, overlap}, {16'h0, ov});
    // n prescaled ticks last from (n-1)*div+1 to n*div timer cycles
    chk("rise gap", 32'(gap_t >= 2 * (1 << ps) + 1 && gap_t <= 3 * (1 << ps)), 32'h1);
    chk("fall gap", 32'(gap_c >= (1 << ps) + 1 && gap_c <= 2 * (1 << ps)), 32'h1);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    results();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("reset pins", {17'h0, pin_t, oe_t, pin_c, oe_c, flag}, 32'h0);
    rd(CDT_OFS_DT);
    chk("dt reset", q, {24'h0, CDT_RST_DT});
    rd(CDT_OFS_TOP);
    chk("top reset", q, {24'h0, CDT_RST_TOP});
    rd(8'h30);
    chk("unmapped", q, 32'h0);
    wr(CDT_OFS_COUNT, 32'h33);
    // flags were set while the counter sat on the compare values
    wr(CDT_OFS_STAT, 32'h7);
    // forced actions in normal mode, every compare output mode
    for (int i = 0; i < 5; i++) begin
      wr(CDT_OFS_MODE, {26'h0, seq[i], seq[i], seq[i]});
      wr(CDT_OFS_FORCE, 32'h7);
      @(posedge clk_i); // generator output lags the waveform by a cycle
      w = (seq[i] == CDT_MODE_TGL) ? ~w : (seq[i] == CDT_MODE_SET) ? 1'b1 :
          (seq[i] == CDT_MODE_CLR) ? 1'b0 : w;
      rd(CDT_OFS_STAT);
      chk("force stat", q & 32'h777, {21'h0, {3{w}}, 1'b0, {3{w}}, 4'h0});
    end
    rd(CDT_OFS_FORCE);
    chk("force reads", q, 32'h0);
    rd(CDT_OFS_COUNT);
    chk("count kept", q, 32'h33);
    // wave is set up before the pins become outputs
    wr(CDT_OFS_PORT, 32'h3F);
    repeat (3) @(posedge clk_i);
    chk("sync pins", {26'h0, pin_t, pin_c}, {26'h0, {3{w}}, {3{~w}}});
    wr(CDT_OFS_CTRL, 32'h1);
    rd(CDT_OFS_STAT);
    chk("wave kept", {29'h0, q[6:4]}, {29'h0, {3{w}}});
    // counter write equal to the compare value on purpose
    wr(CDT_OFS_CTRL, 32'h0);
    wr(CDT_OFS_CMP0, 32'h40);
    wr(CDT_OFS_STAT, 32'h7);
    wr(CDT_OFS_CTRL, 32'h10);
    wr(CDT_OFS_COUNT, 32'h40);
    rd(CDT_OFS_STAT);
    chk("blocked match", {31'h0, q[0]}, 32'h0);
    repeat (300) @(posedge clk_i);
    chk("match flag", {31'h0, flag[0]}, 32'h1);
    // live mode change, one full period holds exactly one channel 0 match
    wr(CDT_OFS_MODE, {26'h0, CDT_MODE_OFF, CDT_MODE_OFF, CDT_MODE_TGL});
    rd(CDT_OFS_STAT);
    w = q[4];
    repeat (253) @(posedge clk_i);
    rd(CDT_OFS_STAT);
    chk("toggle match", {31'h0, q[4]}, {31'h0, ~w});
    // complementary pair with dead time, prescale 1 to 8, then inverted
    wr(CDT_OFS_TOP, 32'h7F);
    wr(CDT_OFS_DT, 32'h32);
    rd(CDT_OFS_DT);
    chk("dt rw", q, 32'h32);
    wr(CDT_OFS_MODE, {26'h0, CDT_MODE_TGL, CDT_MODE_TGL, CDT_MODE_TGL});
    for (int p = 0; p < 4; p++) begin
      dt_run(p, 1'b0);
    end
    dt_run(0, 1'b1);
    // port override follows any set mode bit
    wr(CDT_OFS_CTRL, 32'h0);
    inv_r <= 1'b0;
    wr(CDT_OFS_MODE, 32'h0);
    wr(CDT_OFS_PORT, 32'h3F3F);
    repeat (3) @(posedge clk_i);
    chk("port value", {26'h0, pin_t, pin_c}, 32'h3F);
    wr(CDT_OFS_MODE, 32'hC);
    wr(CDT_OFS_FORCE, 32'h2);
    repeat (3) @(posedge clk_i);
    chk("override set", {26'h0, pin_t, pin_c}, 32'h3D);
    wr(CDT_OFS_MODE, 32'h8);
    wr(CDT_OFS_FORCE, 32'h2);
    repeat (3) @(posedge clk_i);
    chk("override clr", {26'h0, pin_t, pin_c}, 32'h2F);
    wr(CDT_OFS_PORT, 32'h3F00);
    repeat (3) @(posedge clk_i);
    chk("dir off", {26'h0, oe_t, oe_c}, 32'h0);
    results();
  end
endmodule
`default_nettype wire
